// >>> logic/fsr_pkg.sv
// constants for the fault, status readback and clear slice
package fsr_pkg;

    // ----------------------------------------------------------------
    // serial frame lengths and falling-edge counts
    // ----------------------------------------------------------------
    localparam int         WORD_W        = 16;
    localparam int         FRAME_W       = 24;
    localparam int         CNT_W         = 5;
    localparam logic [4:0] CNT_PLAIN     = 5'h10;  // 16-bit frame
    localparam logic [4:0] CNT_CRC       = 5'h18;  // 16 bits plus check byte
    localparam logic [4:0] CNT_LAUNCH    = 5'h04;  // falls seen before 5th rise
    localparam logic [4:0] CNT_MAX       = 5'h1F;  // counter saturates here

    // ----------------------------------------------------------------
    // check sequence
    // ----------------------------------------------------------------
    localparam logic [7:0] CRC_POLY      = 8'h07;  // x^8 + x^2 + x + 1
    localparam logic [7:0] CRC_INIT      = 8'h00;

    // ----------------------------------------------------------------
    // word field positions
    // ----------------------------------------------------------------
    localparam int         ADDR_HI       = 15;
    localparam int         ADDR_LO       = 13;
    localparam int         RW_BIT        = 12;
    localparam int         RANGE_HI      = 10;
    localparam int         RANGE_LO      = 7;
    localparam int         CLEAR_LEVEL_SEL_BIT    = 6;
    localparam int         OUTPUT_DRIVE_ON_BIT     = 5;
    localparam int         SENSE_RESISTOR_SEL_BIT      = 4;
    localparam int         SWCLR_BIT     = 3;  // write frames only
    localparam int         SWRST_BIT     = 2;  // write frames only
    localparam logic [1:0] READ_MARK     = 2'h2; // bits 12:11 of a read word

    // ----------------------------------------------------------------
    // reset values of the settings
    // ----------------------------------------------------------------
    localparam logic [3:0] RANGE_RST     = 4'h0;
    localparam logic       CLEAR_LEVEL_SEL_RST    = 1'h0;
    localparam logic       OUTPUT_DRIVE_ON_RST     = 1'h0;
    localparam logic       SENSE_RESISTOR_SEL_RST      = 1'h0;
    localparam logic       SWCLR_RST     = 1'h0;

    // ----------------------------------------------------------------
    // synchroniser vector layout
    // ----------------------------------------------------------------
    localparam int         SY_W          = 16;
    localparam int         SY_ADDR_LO    = 0;   // three address straps
    localparam int         SY_STRAP      = 3;
    localparam int         SY_RANGE_LO   = 4;   // four range pins
    localparam int         SY_SENSE_RESISTOR_SEL       = 8;
    localparam int         SY_CLEAR_LEVEL_SEL     = 9;
    localparam int         SY_CLEAR      = 10;
    localparam int         SY_OTEMP      = 11;
    localparam int         SY_OPEN       = 12;
    localparam int         SY_SHORT      = 13;
    localparam int         SY_SYNC       = 14;
    localparam int         SY_RDTOG      = 15;
    localparam logic [1:0] STRAP_WAIT    = 2'h3; // edges until straps settle

endpackage

// >>> logic/fsr_core.sv
// serial readback, fault alarms and clear control of the output driver
`timescale 1ns/1ps

module fsr_core
    import fsr_pkg::*;
(
    // system clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // serial link from the host
    input  wire logic       sclk,
    input  wire logic       sync_n,
    input  wire logic       sdi,
    output logic            sdo_o,
    output logic            sdo_oe,
    // straps and configuration pins
    input  wire logic       dev_addr_bit2,
    input  wire logic       dev_addr_bit1,
    input  wire logic       dev_addr_bit0,
    input  wire logic       pin_config_strap,
    input  wire logic       range_code_bit3,
    input  wire logic       range_code_bit2,
    input  wire logic       range_code_bit1,
    input  wire logic       range_code_bit0,
    input  wire logic       sense_resistor_sel,
    input  wire logic       clear_level_sel,
    input  wire logic       clear_in,
    // fault detectors of the analog stage
    input  wire logic       overtemp_det,
    input  wire logic       loop_open_det,
    input  wire logic       voltage_out_short_det,
    // open-drain alarms
    output logic            fault_alarm_n_o,
    output logic            fault_alarm_oe,
    output logic            loop_open_alarm_n_o,
    output logic            loop_open_alarm_oe,
    output logic            voltage_out_short_alarm_n_o,
    output logic            voltage_out_short_alarm_oe,
    output logic            overtemp_alarm_n_o,
    output logic            overtemp_alarm_oe,
    // settings to the analog stage
    output logic [3:0]      range_code_o,
    output logic            sense_resistor_o,
    output logic            output_drive_on,
    output logic            clear_active,
    output logic            clear_level
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------

    // one serial step of the check sequence, msb first
    function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        crc8_step = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    endfunction

    // remainder of a whole 24-bit frame; zero when the check byte is right
    function automatic logic [7:0] crc8_frame(input logic [FRAME_W-1:0] f);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = FRAME_W - 1; i >= 0; i--) begin
            c = crc8_step(c, f[i]);
        end
        crc8_frame = c;
    endfunction

    // ----------------------------------------------------------------
    // link side: falling edges sample data in
    // ----------------------------------------------------------------
    logic               in_frame_q;
    logic               in_frame_d;
    logic [CNT_W-1:0]   fcnt_q;
    logic [CNT_W-1:0]   fcnt_d;
    logic [FRAME_W-1:0] ish_q;
    logic [FRAME_W-1:0] ish_d;

    // first fall of a frame restarts count and shifter
    always_comb begin
        in_frame_d = 1'b1;
        if (!in_frame_q) begin
            fcnt_d = 5'h01;
            ish_d  = {{(FRAME_W-1){1'b0}}, sdi};
        end else begin
            fcnt_d = (fcnt_q == CNT_MAX) ? fcnt_q : fcnt_q + 5'h01;
            ish_d  = {ish_q[FRAME_W-2:0], sdi};
        end
    end

    // frame flag is dropped by sync itself, the clock may stop after the frame
    always_ff @(negedge sclk or negedge rst_b or posedge sync_n) begin
        if (!rst_b) begin
            in_frame_q <= 1'b0;
        end else if (sync_n) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= in_frame_d;
        end
    end

    // count and shifter hold after the frame for the system side to read
    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            fcnt_q <= '0;
            ish_q  <= '0;
        end else begin
            fcnt_q <= fcnt_d;
            ish_q  <= ish_d;
        end
    end

    // ----------------------------------------------------------------
    // link side: rising edges launch readback data
    // ----------------------------------------------------------------
    logic [WORD_W:0]    hold_q;     // readback word plus read-allowed bit
    logic               sdo_q;
    logic               sdo_d;
    logic               sdo_oe_q;
    logic               sdo_oe_d;
    logic [WORD_W-1:0]  osh_q;
    logic [WORD_W-1:0]  osh_d;
    logic               rd_tog_q;
    logic               rd_tog_d;
    logic               launch;

    assign launch = in_frame_q && (fcnt_q == CNT_LAUNCH) && ish_q[0]
                    && (ish_q[3:1] == hold_q[ADDR_HI:ADDR_LO]) && hold_q[WORD_W];

    always_comb begin
        sdo_d    = sdo_q;
        sdo_oe_d = sdo_oe_q;
        osh_d    = osh_q;
        rd_tog_d = rd_tog_q;
        if (launch) begin
            sdo_oe_d = 1'b1;
            sdo_d    = hold_q[WORD_W-1];
            osh_d    = {hold_q[WORD_W-2:0], 1'b0};
            rd_tog_d = ~rd_tog_q;
        end else if (sdo_oe_q) begin
            sdo_d    = osh_q[WORD_W-1];
            osh_d    = {osh_q[WORD_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge sclk or negedge rst_b or posedge sync_n) begin
        if (!rst_b) begin
            sdo_q    <= 1'b0;
            sdo_oe_q <= 1'b0;
            osh_q    <= '0;
        end else if (sync_n) begin
            sdo_q    <= 1'b0;
            sdo_oe_q <= 1'b0;
            osh_q    <= '0;
        end else begin
            sdo_q    <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
            osh_q    <= osh_d;
        end
    end

    // read event toggle, crossed to the system side
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_tog_q <= 1'b0;
        end else begin
            rd_tog_q <= rd_tog_d;
        end
    end

    assign sdo_o  = sdo_q;
    assign sdo_oe = sdo_oe_q;

    // ----------------------------------------------------------------
    // system side: synchronisers and strap capture
    // ----------------------------------------------------------------
    logic [SY_W-1:0]    sy_raw;
    logic [SY_W-1:0]    sy1_q;
    logic [SY_W-1:0]    sy2_q;

    assign sy_raw = {rd_tog_q, sync_n, voltage_out_short_det, loop_open_det, overtemp_det,
                     clear_in, clear_level_sel, sense_resistor_sel,
                     range_code_bit3, range_code_bit2, range_code_bit1, range_code_bit0,
                     pin_config_strap, dev_addr_bit2, dev_addr_bit1, dev_addr_bit0};

    // two flops on every pin but sclk and sdi, and on the link-side toggle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sy1_q <= SY_W'(1) << SY_SYNC;  // sync idles high, no false frame end
            sy2_q <= SY_W'(1) << SY_SYNC;
        end else begin
            sy1_q <= sy_raw;
            sy2_q <= sy1_q;
        end
    end

    logic [2:0]         addr_s;
    logic [3:0]         range_s;
    logic               otemp_s;
    logic               open_s;
    logic               short_s;

    assign addr_s  = sy2_q[SY_ADDR_LO+2:SY_ADDR_LO];
    assign range_s = sy2_q[SY_RANGE_LO+3:SY_RANGE_LO];
    assign otemp_s = sy2_q[SY_OTEMP];
    assign open_s  = sy2_q[SY_OPEN];
    assign short_s = sy2_q[SY_SHORT];

    // ----------------------------------------------------------------
    // system side: frame decode
    // ----------------------------------------------------------------
    logic               sync_prev_q;
    logic               rdtog_prev_q;
    logic [1:0]         strap_cnt_q;
    logic               hw_mode_q;
    logic               frame_end;
    logic               rd_seen;
    logic [WORD_W-1:0]  fword;
    logic               len_ok;
    logic               crc_ok;
    logic               addressed;
    logic               wr_ok;
    logic               crc_fail;

    assign frame_end = sy2_q[SY_SYNC] && !sync_prev_q;
    assign rd_seen   = sy2_q[SY_RDTOG] ^ rdtog_prev_q;
    assign fword     = (fcnt_q == CNT_CRC) ? ish_q[FRAME_W-1:FRAME_W-WORD_W]
                                           : ish_q[WORD_W-1:0];
    assign len_ok    = (fcnt_q == CNT_PLAIN) || (fcnt_q == CNT_CRC);
    assign crc_ok    = (crc8_frame(ish_q) == 8'h00);
    assign addressed = (fword[ADDR_HI:ADDR_LO] == addr_s);
    assign wr_ok     = frame_end && !hw_mode_q && len_ok && addressed && !fword[RW_BIT]
                       && ((fcnt_q == CNT_PLAIN) || crc_ok);
    assign crc_fail  = frame_end && !hw_mode_q && (fcnt_q == CNT_CRC) && addressed
                       && !crc_ok;

    // ----------------------------------------------------------------
    // system side: settings, flags and outputs
    // ----------------------------------------------------------------
    logic [3:0]         range_q;
    logic [3:0]         range_d;
    logic               clear_level_sel_q;
    logic               clear_level_sel_d;
    logic               output_drive_on_q;
    logic               output_drive_on_d;
    logic               sense_resistor_sel_q;
    logic               sense_resistor_sel_d;
    logic               swclr_q;
    logic               swclr_d;
    logic               crc_err_q;
    logic               crc_err_d;
    logic [1:0]         strap_cnt_d;
    logic               hw_mode_d;
    logic [3:0]         flags;
    logic [WORD_W:0]    hold_d;
    logic [15:0]        out_q;
    logic [15:0]        out_d;

    assign flags = {crc_err_q, otemp_s, open_s, short_s};

    // next values of settings, flags, readback word and outputs
    always_comb begin
        range_d     = range_q;
        clear_level_sel_d    = clear_level_sel_q;
        output_drive_on_d     = output_drive_on_q;
        sense_resistor_sel_d      = sense_resistor_sel_q;
        swclr_d     = swclr_q;
        crc_err_d   = crc_err_q;
        strap_cnt_d = strap_cnt_q;
        hw_mode_d   = hw_mode_q;
        // catch the mode strap once, after the synchroniser has filled
        if (strap_cnt_q != STRAP_WAIT) begin
            strap_cnt_d = strap_cnt_q + 2'h1;
            if (strap_cnt_d == STRAP_WAIT) begin
                hw_mode_d = sy2_q[SY_STRAP];
            end
        end
        if (wr_ok) begin
            if (fword[SWRST_BIT]) begin
                range_d  = RANGE_RST;
                clear_level_sel_d = CLEAR_LEVEL_SEL_RST;
                output_drive_on_d  = OUTPUT_DRIVE_ON_RST;
                sense_resistor_sel_d   = SENSE_RESISTOR_SEL_RST;
                swclr_d  = SWCLR_RST;
            end else begin
                range_d  = fword[RANGE_HI:RANGE_LO];
                clear_level_sel_d = fword[CLEAR_LEVEL_SEL_BIT];
                output_drive_on_d  = fword[OUTPUT_DRIVE_ON_BIT];
                sense_resistor_sel_d   = fword[SENSE_RESISTOR_SEL_BIT];
                swclr_d  = fword[SWCLR_BIT];
            end
        end
        if (crc_fail) begin
            crc_err_d = 1'b1;
        end else if (rd_seen) begin
            crc_err_d = 1'b0;
        end
        if (sy2_q[SY_SYNC]) begin
            hold_d = {!hw_mode_q, addr_s, READ_MARK, range_q, clear_level_sel_q, output_drive_on_q,
                      sense_resistor_sel_q, flags};
        end else begin
            hold_d = hold_q;
        end
        out_d = '0;
        out_d[3:0] = hw_mode_q ? range_s : range_q;
        out_d[4]   = hw_mode_q ? sy2_q[SY_SENSE_RESISTOR_SEL] : sense_resistor_sel_q;
        out_d[5]   = hw_mode_q ? 1'b1 : output_drive_on_q;
        out_d[6]   = sy2_q[SY_CLEAR] || swclr_q;
        out_d[7]   = sy2_q[SY_CLEAR_LEVEL_SEL] || clear_level_sel_q;
        out_d[8]   = !hw_mode_q && (|flags);
        out_d[9]   = hw_mode_q && open_s;
        out_d[10]  = hw_mode_q && short_s;
        out_d[11]  = hw_mode_q && otemp_s;
    end

    // registers of the system side
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_prev_q  <= 1'b1;
            rdtog_prev_q <= 1'b0;
            strap_cnt_q  <= 2'h0;
            hw_mode_q    <= 1'b0;
            range_q      <= RANGE_RST;
            clear_level_sel_q     <= CLEAR_LEVEL_SEL_RST;
            output_drive_on_q      <= OUTPUT_DRIVE_ON_RST;
            sense_resistor_sel_q       <= SENSE_RESISTOR_SEL_RST;
            swclr_q      <= SWCLR_RST;
            crc_err_q    <= 1'b0;
            hold_q       <= '0;
            out_q        <= '0;
        end else begin
            sync_prev_q  <= sy2_q[SY_SYNC];
            rdtog_prev_q <= sy2_q[SY_RDTOG];
            strap_cnt_q  <= strap_cnt_d;
            hw_mode_q    <= hw_mode_d;
            range_q      <= range_d;
            clear_level_sel_q     <= clear_level_sel_d;
            output_drive_on_q      <= output_drive_on_d;
            sense_resistor_sel_q       <= sense_resistor_sel_d;
            swclr_q      <= swclr_d;
            crc_err_q    <= crc_err_d;
            hold_q       <= hold_d;
            out_q        <= out_d;
        end
    end

    // ----------------------------------------------------------------
    // output map; alarm levels come from a flop held low
    // ----------------------------------------------------------------
    assign range_code_o         = out_q[3:0];
    assign sense_resistor_o     = out_q[4];
    assign output_drive_on      = out_q[5];
    assign clear_active         = out_q[6];
    assign clear_level          = out_q[7];
    assign fault_alarm_oe       = out_q[8];
    assign loop_open_alarm_oe   = out_q[9];
    assign voltage_out_short_alarm_oe  = out_q[10];
    assign overtemp_alarm_oe    = out_q[11];
    assign fault_alarm_n_o      = out_q[12];
    assign loop_open_alarm_n_o  = out_q[13];
    assign voltage_out_short_alarm_n_o = out_q[14];
    assign overtemp_alarm_n_o   = out_q[15];

endmodule

// >>> verification/fsr_core_assertions.sv
// concurrent checks on the ports of the fault, status readback and clear slice
`timescale 1ns/1ps

module fsr_core_assertions (
    // clocks, reset and link
    input wire logic clk, rst_b, sclk, sync_n, sdo_oe,
    // mode strap, fault detectors and clear
    input wire logic pin_config_strap, overtemp_det, loop_open_det, voltage_out_short_det,
    input wire logic clear_in, clear_level_sel, clear_active, clear_level,
    // alarms
    input wire logic fault_alarm_n_o, fault_alarm_oe, loop_open_alarm_n_o,
    input wire logic loop_open_alarm_oe, voltage_out_short_alarm_oe
);
    // ------------------------------------------------------------
    // rising link edges seen since the frame opened
    // ------------------------------------------------------------
    logic [4:0] rise_q, rise_d;

    // saturate so a long frame never wraps back to the launch count
    always_comb rise_d = (rise_q == 5'h1F) ? rise_q : rise_q + 5'h01;

    // frame sync high clears the count at once
    always_ff @(posedge sclk or posedge sync_n) begin
        if (sync_n) rise_q <= 5'h00;
        else rise_q <= rise_d;
    end

    // a condition held five system edges must show at the output
    property held5(c, r);
        @(posedge clk) disable iff (!rst_b) c [*5] |-> r;
    endproperty

    chk_launch_fifth: assert property (@(posedge sclk) disable iff (!rst_b)
        $rose(sdo_oe) |-> rise_q == 5'h05) else $error("read launch not on fifth rise");
    chk_drive_in_frame: assert property (@(posedge clk) disable iff (!rst_b)
        sdo_oe |-> !sync_n && rise_q >= 5'h05) else $error("data out driven outside a read");
    chk_pin_no_read: assert property (@(posedge clk) disable iff (!rst_b)
        pin_config_strap |-> !sdo_oe) else $error("readback in pin mode");
    chk_alarm_on_fault: assert property (held5(!pin_config_strap &&
        (overtemp_det | loop_open_det | voltage_out_short_det), fault_alarm_oe))
        else $error("shared alarm missing");
    chk_pin_loop_alarm: assert property (held5(pin_config_strap && loop_open_det,
        loop_open_alarm_oe)) else $error("loop alarm missing");
    chk_live_drop: assert property (held5(pin_config_strap && !voltage_out_short_det,
        !voltage_out_short_alarm_oe)) else $error("short alarm stuck");
    chk_open_drain: assert property (@(posedge clk) disable iff (!rst_b)
        !(fault_alarm_n_o | loop_open_alarm_n_o)) else $error("alarm driven high");
    chk_sw_no_pin: assert property (@(posedge clk) disable iff (!rst_b)
        !pin_config_strap |-> !loop_open_alarm_oe) else $error("pin alarm in software mode");
    chk_clear_follow: assert property (held5(clear_in, clear_active))
        else $error("clear not active");
    chk_clear_sel_or: assert property (held5(clear_level_sel, clear_level))
        else $error("clear level pin ignored");

    cover property (@(posedge sclk) $rose(sdo_oe));
    cover property (@(posedge clk) fault_alarm_oe);
    cover property (@(posedge clk) loop_open_alarm_oe);
endmodule

bind fsr_core fsr_core_assertions i_chk (.clk, .rst_b, .sclk, .sync_n, .sdo_oe,
    .pin_config_strap, .overtemp_det, .loop_open_det, .voltage_out_short_det, .clear_in,
    .clear_level_sel, .clear_active, .clear_level, .fault_alarm_n_o, .fault_alarm_oe,
    .loop_open_alarm_n_o, .loop_open_alarm_oe, .voltage_out_short_alarm_oe);

// >>> verification/fsr_host_model.sv
// host serial master model that drives the link of the slice
`timescale 1ns/1ps

module fsr_host_model (
    // serial link
    output logic        sclk,
    output logic        sync_n,
    output logic        sdi,
    input  wire logic   sdo,
    // word captured by a read frame
    output logic        rd_stb,
    output logic [15:0] rd_word
);
    // link clock stands still and sync stays high between frames
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdi = 1'b0;
        rd_stb = 1'b0;
        rd_word = 16'h0000;
    end

    // check byte over the word, msb first
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    // one frame of n clock pulses; bad spoils the check byte
    task automatic frame(input logic [15:0] w, input int n, input bit bad, input bit rd);
        logic [23:0] f;
        logic [15:0] got;
        f = {w, crc8(w) ^ {8{bad}}};
        got = 16'h0000;
        #3 sync_n = 1'b0;
        #200;
        for (int k = 0; k < n; k++) begin
            #3.75 sdi = f[23-k];
            #3.75 sclk = 1'b1;
            #7.5 sclk = 1'b0;
            if (k >= 4 && k < 20) got = {got[14:0], sdo};
        end
        // sync rises once the data is out
        #10 sync_n = 1'b1;
        sdi = ~sdi;
        if (rd) begin
            rd_word = got;
            rd_stb = 1'b1;
            #1 rd_stb = 1'b0;
        end
        #250;
    endtask
endmodule

// >>> verification/tb_top.sv
// self-checking testbench for the fault, status readback and clear slice
`timescale 1ns/1ps

module tb_top;
    import fsr_pkg::*;
    // ------------------------------------------------------------
    // stimulus, observed signals and bookkeeping
    // ------------------------------------------------------------
    logic clk = 1'b0, rst_b = 1'b0, pin_config_strap = 1'b0, sense_resistor_sel = 1'b0;
    logic clear_level_sel = 1'b0, clear_in = 1'b0, alt_q = 1'b0;
    logic overtemp_det = 1'b0, loop_open_det = 1'b0, voltage_out_short_det = 1'b0;
    logic range_code_bit3 = 1'b0, range_code_bit2 = 1'b0, range_code_bit1 = 1'b0;
    logic range_code_bit0 = 1'b0, dev_addr_bit2 = 1'b1, dev_addr_bit1 = 1'b0;
    logic dev_addr_bit0 = 1'b1, sclk, sync_n, sdi, sdo_o, sdo_oe, rd_stb;
    logic fault_alarm_n_o, fault_alarm_oe, loop_open_alarm_n_o, loop_open_alarm_oe;
    logic voltage_out_short_alarm_n_o, voltage_out_short_alarm_oe, overtemp_alarm_n_o, overtemp_alarm_oe;
    logic sense_resistor_o, output_drive_on, clear_active, clear_level, cs, oe, rs;
    logic [3:0]  range_code_o, rng;
    logic [15:0] rd_word, exp_q[$];
    wire  [2:0]  addr = {dev_addr_bit2, dev_addr_bit1, dev_addr_bit0};
    wire         sdo_line = sdo_oe ? sdo_o : alt_q; // released line keeps changing
    int          num_errors = 0, checked = 0, cyc = 0, seed = 32'h07a909f4;

    fsr_core i_dut (.clk, .rst_b, .sclk, .sync_n, .sdi, .sdo_o, .sdo_oe, .dev_addr_bit2,
        .dev_addr_bit1, .dev_addr_bit0, .pin_config_strap, .range_code_bit3, .range_code_bit2,
        .range_code_bit1, .range_code_bit0, .sense_resistor_sel, .clear_level_sel, .clear_in,
        .overtemp_det, .loop_open_det, .voltage_out_short_det, .fault_alarm_n_o, .fault_alarm_oe,
        .loop_open_alarm_n_o, .loop_open_alarm_oe, .voltage_out_short_alarm_n_o, .voltage_out_short_alarm_oe,
        .overtemp_alarm_n_o, .overtemp_alarm_oe, .range_code_o, .sense_resistor_o,
        .output_drive_on, .clear_active, .clear_level);
    fsr_host_model i_host (.sclk, .sync_n, .sdi, .sdo(sdo_line), .rd_stb, .rd_word);

    always #25 clk = ~clk;

    // idle pattern for the data line and the hang limit
    always @(posedge clk) begin
        alt_q <= ~alt_q;
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            report_and_stop;
        end
    end

    // each read word is compared with the oldest note
    always @(posedge rd_stb) check("readback", rd_word, exp_q.pop_front());

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wclk(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic reset(input logic s);
        @(posedge clk) begin
            rst_b <= 1'b0;
            pin_config_strap <= s;
        end
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        {rng, cs, oe, rs} = {RANGE_RST, CLEAR_LEVEL_SEL_RST, OUTPUT_DRIVE_ON_RST, SENSE_RESISTOR_SEL_RST};
        wclk(4);
    endtask

    task automatic wr(input logic [3:0] r, input logic c, e, s, sw, input bit bad);
        i_host.frame({addr, 2'h0, r, c, e, s, sw, 3'h0}, 24, bad, 1'b0);
        if (!bad) {rng, cs, oe, rs} = {r, c, e, s};
        wclk(8);
    endtask

    task automatic rd(input logic [3:0] fl);
        exp_q.push_back({addr, READ_MARK, rng, cs, oe, rs, fl});
        i_host.frame({addr, 1'b1, 12'($random(seed))}, 20, 1'b0, 1'b1);
        wclk(6);
    endtask

    task automatic cfg;
        check("settings", {5'h0, fault_alarm_n_o, loop_open_alarm_n_o, voltage_out_short_alarm_n_o,
            overtemp_alarm_n_o, range_code_o, clear_level, output_drive_on, sense_resistor_o},
            {9'h0, rng, cs | clear_level_sel, oe | pin_config_strap, rs});
    endtask

    // raise each detector alone, then drop it
    task automatic faults(input bit pin);
        logic [3:0] al;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) {overtemp_det, loop_open_det, voltage_out_short_det} <= 3'h4 >> i;
            wclk(5);
            al = {fault_alarm_oe, overtemp_alarm_oe, loop_open_alarm_oe, voltage_out_short_alarm_oe};
            check("alarms", 16'(al), pin ? 16'(3'h4 >> i) : 16'h8);
            if (!pin) rd({1'b0, 3'h4 >> i});
            @(posedge clk) {overtemp_det, loop_open_det, voltage_out_short_det} <= 3'h0;
            wclk(5);
            al = {fault_alarm_oe, overtemp_alarm_oe, loop_open_alarm_oe, voltage_out_short_alarm_oe};
            check("alarms off", 16'(al), 16'h0);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [3:0] r;
        reset(1'b0);
        cfg;
        r = 4'($random(seed));
        wr(r, r[0], 1'b1, r[1], 1'b0, 1'b0);
        cfg;
        rd(4'h0);
        cfg;
        $display("write and readback done");
        wr(~r, ~r[0], 1'b0, ~r[1], 1'b0, 1'b1);
        cfg;
        check("check alarm", 16'(fault_alarm_oe), 16'h1);
        rd(4'h8);
        rd(4'h0);
        check("check alarm", 16'(fault_alarm_oe), 16'h0);
        $display("check byte done");
        faults(1'b0);
        $display("software faults done");
        @(posedge clk) clear_in <= 1'b1;
        @(posedge clk) clear_level_sel <= 1'b1;
        wclk(5);
        check("clear on", 16'({clear_active, clear_level}), 16'h3);
        @(posedge clk) clear_in <= 1'b0;
        @(posedge clk) clear_level_sel <= 1'b0;
        wclk(5);
        check("clear off", 16'({clear_active, clear_level}), 16'(cs));
        wr(rng, cs, oe, rs, 1'b1, 1'b0);
        check("soft clear", 16'(clear_active), 16'h1);
        wr(rng, cs, oe, rs, 1'b0, 1'b0);
        check("soft clear", 16'(clear_active), 16'h0);
        $display("clear done");
        reset(1'b1);
        @(posedge clk) begin
            {range_code_bit3, range_code_bit2, range_code_bit1, range_code_bit0} <= ~r;
            sense_resistor_sel <= 1'b1;
        end
        i_host.frame({addr, 1'b1, 12'h0}, 20, 1'b0, 1'b0);
        i_host.frame({addr, 2'h0, r, 7'h0}, 16, 1'b0, 1'b0);
        {rng, rs} = {~r, 1'b1};
        wclk(8);
        cfg;
        faults(1'b1);
        $display("pin mode done");
        report_and_stop;
    end
endmodule
